// *** rtl/serial_port_pkg.sv ***
package serial_port_pkg;

   // three-level strap reading from the pad detector
   typedef enum logic [1:0]
   {
      STRAP_LOW  = 2'b00,
      STRAP_OPEN = 2'b01,
      STRAP_HIGH = 2'b10
   } strap_level_t;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_WRITE  = 3'b010,
      ST_READ   = 3'b011,
      ST_IGNORE = 3'b100
   } port_state_t;

   // register access request towards the configuration registers
   typedef struct packed
   {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   localparam logic [3:0] SLAVE_ADDR_HI   = 4'hB;
   localparam logic [3:0] BIT_ACK         = 4'h8;
   localparam logic [3:0] BIT_ACK_END     = 4'h9;
   localparam logic [1:0] IDX_ADDR_HI     = 2'h0;
   localparam logic [1:0] IDX_ADDR_LO     = 2'h1;
   localparam logic [1:0] IDX_DATA        = 2'h2;
   localparam logic       DIR_READ        = 1'b1;

   // bus rates and sampling margin at the 40 MHz system clock
   localparam int CLK_KHZ          = 40000;
   localparam int SCL_STD_KHZ      = 100;
   localparam int SCL_FAST_KHZ     = 400;
   localparam int FAST_HALF_CYCLES = CLK_KHZ / (2 * SCL_FAST_KHZ);

endpackage

// *** rtl/level_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module level_sync
   import serial_port_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // reset value is a constant at every instance
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q ^ ~reset_val_in ^ ~reset_val_in;

endmodule
`default_nettype wire

// *** rtl/serial_control_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_control_port
   import serial_port_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output var  logic         sda_out,
   output var  logic         sda_oe_out,
   input  wire strap_level_t port_strap_upper_in,
   input  wire strap_level_t port_strap_lower_in,
   output var  logic         spi_enable_out,
   output var  reg_req_t     reg_req_out,
   input  wire logic [7:0]   reg_rdata_in
);

   // line and strap synchronisers
   logic [5:0] sync_s;
   level_sync #(.WIDTH(6)) u_sync
   (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .async_in     ({scl_in, sda_in, port_strap_upper_in, port_strap_lower_in}),
      .reset_val_in ('1),
      .sync_out     (sync_s)
   );

   logic         scl_s;
   logic         sda_s;
   strap_level_t up_s;
   strap_level_t lo_s;
   assign scl_s = sync_s[5];
   assign sda_s = sync_s[4];
   assign up_s  = strap_level_t'(sync_s[3:2]);
   assign lo_s  = strap_level_t'(sync_s[1:0]);

   function automatic logic [1:0] digit(input strap_level_t lvl);
      unique case (lvl)
         STRAP_LOW:  digit = 2'h0;
         STRAP_OPEN: digit = 2'h1;
         default:    digit = 2'h2;
      endcase
   endfunction

   logic         scl_p_q;
   logic         sda_p_q;
   port_state_t  state_q;
   port_state_t  state_d;
   logic [3:0]   bit_q;
   logic [3:0]   bit_d;
   logic [7:0]   shreg_q;
   logic [7:0]   shreg_d;
   logic [1:0]   idx_q;
   logic [1:0]   idx_d;
   logic         rw_q;
   logic         rw_d;
   logic         oe_q;
   logic         oe_d;
   logic         bump_q;
   logic         bump_d;
   logic         spi_q;
   logic         spi_d;
   logic [2:0]   addr_lo_q;
   logic [2:0]   addr_lo_d;
   reg_req_t     req_q;
   reg_req_t     req_d;

   logic         start_ev;
   logic         stop_ev;
   logic         rise_ev;
   logic         fall_ev;
   logic [6:0]   slave_addr;
   logic [3:0]   strap_sum;

   // start and stop are data edges while the clock is high
   // start detect
   assign start_ev   = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev    = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign rise_ev    = scl_s & ~scl_p_q;
   assign fall_ev    = ~scl_s & scl_p_q;
   assign slave_addr = {SLAVE_ADDR_HI, addr_lo_q};
   assign strap_sum  = {2'h0, digit(up_s)} * 4'h3 + {2'h0, digit(lo_s)};

   always_comb
   begin
      state_d   = state_q;
      bit_d     = bit_q;
      shreg_d   = shreg_q;
      idx_d     = idx_q;
      rw_d      = rw_q;
      oe_d      = oe_q;
      bump_d    = 1'b0;
      req_d     = req_q;
      req_d.wr  = 1'b0;
      req_d.rd  = 1'b0;
      spi_d     = (up_s == STRAP_HIGH) && (lo_s == STRAP_HIGH);
      addr_lo_d = strap_sum[2:0];
      if (bump_q)
         req_d.addr = req_q.addr + 16'h1;
      if (start_ev && !spi_q)
      begin
         state_d = ST_ADDR;
         bit_d   = '0;
         idx_d   = IDX_ADDR_HI;
         oe_d    = 1'b0;
      end
      else if (stop_ev || spi_q)
      begin
         state_d = ST_IDLE;
         bit_d   = '0;
         oe_d    = 1'b0;
      end
      else if (rise_ev)
      begin
         unique case (state_q)
            ST_ADDR, ST_WRITE:
            begin
               if (bit_q < BIT_ACK)
                  shreg_d = {shreg_q[6:0], sda_s};
               if (bit_q < BIT_ACK_END)
                  bit_d = bit_q + 4'h1;
            end
            ST_READ:
            begin
               if (bit_q < BIT_ACK)
                  bit_d = bit_q + 4'h1;
               else if (bit_q == BIT_ACK && sda_s)
                  state_d = ST_IGNORE;
               else if (bit_q == BIT_ACK)
                  bit_d = BIT_ACK_END;
            end
            default:
            begin
               bit_d = bit_q;
            end
         endcase
      end
      else if (fall_ev)
      begin
         unique case (state_q)
            ST_ADDR:
            begin
               if (bit_q == BIT_ACK)
               begin
                  if (shreg_q[7:1] == slave_addr)
                  begin
                     oe_d = 1'b1;
                     rw_d = shreg_q[0];
                     req_d.rd = shreg_q[0] == DIR_READ;
                  end
                  else
                     state_d = ST_IGNORE;
               end
               else if (bit_q == BIT_ACK_END)
               begin
                  bit_d = '0;
                  if (rw_q == DIR_READ)
                  begin
                     state_d    = ST_READ;
                     shreg_d    = reg_rdata_in;
                     oe_d       = ~reg_rdata_in[7];
                     req_d.addr = req_q.addr + 16'h1;
                  end
                  else
                  begin
                     state_d = ST_WRITE;
                     oe_d    = 1'b0;
                  end
               end
            end
            ST_WRITE:
            begin
               if (bit_q == BIT_ACK)
               begin
                  oe_d = 1'b1;
                  unique case (idx_q)
                     IDX_ADDR_HI: req_d.addr[15:8] = shreg_q;
                     IDX_ADDR_LO: req_d.addr[7:0]  = shreg_q;
                     default:
                     begin
                        req_d.wdata = shreg_q;
                        req_d.wr    = 1'b1;
                        bump_d      = 1'b1;
                     end
                  endcase
                  if (idx_q != IDX_DATA)
                     idx_d = idx_q + 2'h1;
               end
               else if (bit_q == BIT_ACK_END)
               begin
                  oe_d  = 1'b0;
                  bit_d = '0;
               end
            end
            ST_READ:
            begin
               if (bit_q < BIT_ACK)
               begin
                  // drive next bit while clock low
                  shreg_d = {shreg_q[6:0], 1'b1};
                  oe_d    = ~shreg_q[6];
               end
               if (bit_q == BIT_ACK)
               begin
                  // release for the master's ack slot
                  oe_d     = 1'b0;
                  req_d.rd = 1'b1;
               end
               else if (bit_q == BIT_ACK_END)
               begin
                  bit_d      = '0;
                  shreg_d    = reg_rdata_in;
                  oe_d       = ~reg_rdata_in[7];
                  req_d.addr = req_q.addr + 16'h1;
               end
            end
            default:
            begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // only the data line has a driver; no sleep gating
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
         state_q   <= ST_IDLE;
         bit_q     <= '0;
         shreg_q   <= '0;
         idx_q     <= IDX_ADDR_HI;
         rw_q      <= 1'b0;
         oe_q      <= 1'b0;
         bump_q    <= 1'b0;
         spi_q     <= 1'b0;
         addr_lo_q <= '0;
         req_q     <= '0;
      end
      else
      begin
         scl_p_q   <= scl_s;
         sda_p_q   <= sda_s;
         state_q   <= state_d;
         bit_q     <= bit_d;
         shreg_q   <= shreg_d;
         idx_q     <= idx_d;
         rw_q      <= rw_d;
         oe_q      <= oe_d;
         bump_q    <= bump_d;
         spi_q     <= spi_d;
         addr_lo_q <= addr_lo_d;
         req_q     <= req_d;
      end
   end

   assign sda_out        = 1'b0;
   assign sda_oe_out     = oe_q;
   assign spi_enable_out = spi_q;
   assign reg_req_out    = req_q;

   property p_spi_silent;
      @(posedge clk_in) disable iff (reset_in) spi_q |=> !oe_q && state_q == ST_IDLE;
   endproperty
   a_spi_silent: assert property (p_spi_silent) else $error("port answered in spi mode");

   property p_addr_miss;
      @(posedge clk_in) disable iff (reset_in)
      (fall_ev && state_q == ST_ADDR && bit_q == BIT_ACK && !start_ev && !stop_ev && !spi_q
       && shreg_q[7:4] != SLAVE_ADDR_HI) |=> state_q == ST_IGNORE && !oe_q;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

   property p_addr_hit;
      @(posedge clk_in) disable iff (reset_in)
      (fall_ev && state_q == ST_ADDR && bit_q == BIT_ACK && !start_ev && !stop_ev && !spi_q
       && shreg_q[7:1] == slave_addr) |=> oe_q;
   endproperty
   a_addr_hit: assert property (p_addr_hit) else $error("own address not acknowledged");

   property p_change_low;
      @(posedge clk_in) disable iff (reset_in) $changed(oe_q) && !spi_q && !$past(stop_ev)
      && !$past(start_ev) |-> !scl_s;
   endproperty
   a_change_low: assert property (p_change_low) else $error("data changed while clock high");

   property p_start;
      @(posedge clk_in) disable iff (reset_in)
      start_ev && !spi_q |=> state_q == ST_ADDR && bit_q == '0 && !oe_q;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge clk_in) disable iff (reset_in) stop_ev |=> state_q == ST_IDLE && !oe_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_write_ack;
      @(posedge clk_in) disable iff (reset_in)
      (fall_ev && state_q == ST_WRITE && bit_q == BIT_ACK && !stop_ev && !start_ev && !spi_q)
      |=> oe_q;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");

   property p_read_nack;
      @(posedge clk_in) disable iff (reset_in)
      (rise_ev && state_q == ST_READ && bit_q == BIT_ACK && sda_s && !spi_q)
      |=> state_q == ST_IGNORE ##1 !oe_q;
   endproperty
   a_read_nack: assert property (p_read_nack) else $error("line held after not-ack");

   property p_addr_step;
      @(posedge clk_in) disable iff (reset_in)
      req_q.wr |=> ##1 req_q.addr == $past(req_q.addr, 2) + 16'h1;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address did not advance");

   property p_bit_count;
      @(posedge clk_in) disable iff (reset_in)
      (rise_ev && state_q == ST_ADDR && bit_q < BIT_ACK && !spi_q) |=> bit_q == $past(bit_q) + 4'h1;
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("bit count slipped");

endmodule
`default_nettype wire

// *** verif/i2c_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model
(
   input  wire logic clk_in,
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_pull_out
);
   int lo_cyc = 5;
   int hi_cyc = 3;

   initial
   begin
      scl_out      = 1'b1;
      sda_pull_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // data set in clock low, one pulse
   task automatic send_bit(input logic b, output logic s);
      sda_pull_out <= ~b;
      tick(lo_cyc - 1);
      scl_out <= 1'b1;
      tick(hi_cyc - 1);
      s = sda_in;
      tick(1);
      scl_out <= 1'b0;
      tick(1);
   endtask

   task automatic xfer_byte(input logic [7:0] d, input logic ack_b,
                            output logic [7:0] r, output logic ack_s);
      for (int i = 7; i >= 0; i--)
         send_bit(d[i], r[i]);
      send_bit(ack_b, ack_s);
   endtask

   task automatic start_cond();
      sda_pull_out <= 1'b0;
      tick(lo_cyc);
      scl_out <= 1'b1;
      tick(hi_cyc);
      sda_pull_out <= 1'b1;
      tick(hi_cyc);
      scl_out <= 1'b0;
      tick(1);
   endtask

   task automatic stop_cond();
      sda_pull_out <= 1'b1;
      tick(lo_cyc - 1);
      scl_out <= 1'b1;
      tick(hi_cyc);
      sda_pull_out <= 1'b0;
      tick(hi_cyc);
   endtask
endmodule
`default_nettype wire

// *** verif/i2c_serial_control_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2c_serial_control_port_tb
   import serial_port_pkg::*;
();
   localparam int         LIMIT = 60000;
   localparam logic [6:0] DEV   = {4'hB, 3'h0};

   logic         clk       = 1'b0;
   logic         reset     = 1'b1;
   strap_level_t strap_hi  = STRAP_LOW;
   strap_level_t strap_lo  = STRAP_LOW;
   logic [7:0]   reg_rdata = 8'h00;
   logic [7:0]   mem [0:511] = '{default: 8'h00};
   logic [7:0]   exp_d [3] = '{8'hA5, 8'h5A, 8'hC3};
   logic         scl;
   logic         m_pull;
   logic         sda;
   logic         dut_sda;
   logic         dut_oe;
   logic         spi_en;
   reg_req_t     req;
   logic         scl_prev  = 1'b1;
   logic         oe_prev   = 1'b0;
   int           n_errors  = 0;
   int           checked   = 0;
   int           n_wr      = 0;
   int           n_rd      = 0;
   int           n_cycles  = 0;

   assign sda = ~(m_pull | (dut_oe & ~dut_sda));

   initial forever #12.5 clk = ~clk;

   serial_control_port u_dut
   (
      .clk_in              (clk),
      .reset_in            (reset),
      .scl_in              (scl),
      .sda_in              (sda),
      .sda_out             (dut_sda),
      .sda_oe_out          (dut_oe),
      .port_strap_upper_in (strap_hi),
      .port_strap_lower_in (strap_lo),
      .spi_enable_out      (spi_en),
      .reg_req_out         (req),
      .reg_rdata_in        (reg_rdata)
   );

   i2c_master_model u_m
   (
      .clk_in       (clk),
      .sda_in       (sda),
      .scl_out      (scl),
      .sda_pull_out (m_pull)
   );

   always @(posedge clk)
   begin
      if (req.wr === 1'b1)
      begin
         mem[req.addr[8:0]] <= req.wdata;
         n_wr <= n_wr + 1;
      end
      if (req.rd === 1'b1)
         n_rd <= n_rd + 1;
      reg_rdata <= mem[req.addr[8:0]];
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
         n_errors++;
      end
   endtask

   task automatic finish_test();
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      n_cycles <= n_cycles + 1;
      if (!reset && scl_prev && scl)
         check("data held in clock high", {15'h0, dut_oe}, {15'h0, oe_prev});
      scl_prev <= scl;
      oe_prev <= dut_oe;
      if (n_cycles == LIMIT)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic put(input logic [7:0] d, input logic acked);
      logic [7:0] r;
      logic       a;
      u_m.xfer_byte(d, 1'b1, r, a);
      check("ack slot", {15'h0, a}, {15'h0, ~acked});
   endtask

   task automatic get(output logic [7:0] d, input logic last);
      logic a;
      u_m.xfer_byte(8'hFF, last, d, a);
   endtask

   task automatic set_ptr(input logic [15:0] p);
      u_m.start_cond();
      put({DEV, 1'b0}, 1'b1);
      put(p[15:8], 1'b1);
      put(p[7:0], 1'b1);
   endtask

   task automatic t_straps();
      logic [6:0] a;
      for (int i = 0; i < 9; i++)
      begin
         strap_hi <= strap_level_t'(2'(i / 3));
         strap_lo <= strap_level_t'(2'(i % 3));
         a = {4'hB, 3'(i)};
         wait_clk(8);
         check("spi enable", {15'h0, spi_en}, {15'h0, i == 8});
         u_m.start_cond();
         put({a, 1'b0}, i != 8);
         u_m.stop_cond();
         u_m.start_cond();
         put({a ^ 7'h01, 1'b0}, 1'b0);
         put(8'h00, 1'b0);
         u_m.stop_cond();
      end
      strap_hi <= STRAP_LOW;
      strap_lo <= STRAP_LOW;
      wait_clk(8);
      check("no writes", 16'(n_wr), 16'h0000);
   endtask

   task automatic t_write_read();
      logic [7:0] d;
      int         rd0;
      set_ptr(16'h00FE);
      for (int i = 0; i < 3; i++)
         put(exp_d[i], 1'b1);
      u_m.stop_cond();
      for (int i = 0; i < 3; i++)
         check("written byte", {8'h00, mem[9'h0FE + 9'(i)]}, {8'h00, exp_d[i]});
      check("next address", req.addr, 16'h0101);
      rd0 = n_rd;
      set_ptr(16'h00FE);
      u_m.start_cond();
      put({DEV, 1'b1}, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         get(d, i == 2);
         check("read byte", {8'h00, d}, {8'h00, exp_d[i]});
      end
      wait_clk(4);
      check("line released", {15'h0, dut_oe}, 16'h0000);
      check("read requests", 16'(n_rd - rd0), 16'h0004);
      u_m.stop_cond();
   endtask

   task automatic t_abort();
      logic s;
      int   w;
      w = n_wr;
      u_m.start_cond();
      for (int i = 6; i > 3; i--)
         u_m.send_bit(DEV[i], s);
      u_m.stop_cond();
      set_ptr(16'h0010);
      for (int i = 0; i < 4; i++)
         u_m.send_bit(1'b1, s);
      set_ptr(16'h0020);
      put(8'h77, 1'b1);
      u_m.stop_cond();
      check("partial byte dropped", {8'h00, mem[9'h010]}, 16'h0000);
      check("full byte kept", {8'h00, mem[9'h020]}, 16'h0077);
      check("write count", 16'(n_wr - w), 16'h0001);
   endtask

   task automatic t_speed();
      logic [7:0] d;
      u_m.lo_cyc = 50;
      u_m.hi_cyc = 50;
      set_ptr(16'h0042);
      put(8'h3C, 1'b1);
      u_m.stop_cond();
      u_m.lo_cyc = 200;
      u_m.hi_cyc = 200;
      set_ptr(16'h0042);
      u_m.start_cond();
      put({DEV, 1'b1}, 1'b1);
      get(d, 1'b1);
      u_m.stop_cond();
      check("slow read", {8'h00, d}, 16'h003C);
   endtask

   initial
   begin
      wait_clk(5);
      reset <= 1'b0;
      wait_clk(6);
      t_straps();
      t_write_read();
      t_abort();
      t_speed();
      finish_test();
   end
endmodule
`default_nettype wire
